// *** design/rdc_pkg.sv ***
package rdc_pkg;
    // Result width and clocking
    localparam int          DATA_W      = 12;
    localparam int          CLK_HZ      = 20_000_000;
    localparam int          PUMP_HZ     = 204_800;
    // Half period of the pump square wave, rounded down to whole cycles
    localparam int          PUMP_HALF   = CLK_HZ / (2 * PUMP_HZ);
    localparam int          PUMP_CNT_W  = 6;
    localparam logic [5:0]  PUMP_LAST   = 6'(PUMP_HALF - 1);

    // Register map, byte addresses
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_POS    = 8'h04;
    localparam logic [7:0]  ADDR_VEL    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS = 8'h0c;

    // Control fields
    localparam int          CTRL_PUMP   = 0;
    localparam int          CTRL_ENC    = 1;
    localparam logic [1:0]  CTRL_RESET  = 2'h3;

    // Status fields
    localparam int          STAT_DIR    = 0;
    localparam int          STAT_SERIAL = 1;
    localparam int          STAT_FRAME  = 2;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    // Serial engine states
    typedef enum logic {
        RDC_SER_IDLE  = 1'b0,
        RDC_SER_SHIFT = 1'b1
    } rdc_ser_state_t;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic               awvalid;
        logic [ADDR_W-1:0]  awaddr;
        logic               wvalid;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bready;
        logic               arvalid;
        logic [ADDR_W-1:0]  araddr;
        logic               rready;
    } rdc_axil_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } rdc_axil_rsp_t;
endpackage : rdc_pkg

// *** design/rdc_readout_port.sv ***
// How it works
// - Sample strobe fall latches both integrators
// - velocity_select high reads position, low velocity
// - Data buffers driven only with select and frame low
// - Port inactive while select_n is high
// - read_frame_n edge frames transfer, level enables output
// - serial_port_select high serial, low parallel
// - Serial bit changes on shift clock rising edge
// - Pin ten is shift clock input in serial mode
// - Other data pins high impedance in serial mode, MSB driven when selected
// - Pump output free running 50 percent square wave
// - Encoder phase A free running while inputs valid
// - Phase B and index marker free running too
// - Direction high while angle increases
`timescale 1ns/10ps
`default_nettype none
module rdc_readout_port (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire rdc_pkg::rdc_axil_req_t axiReq,
    output var  rdc_pkg::rdc_axil_rsp_t axiRsp,
    input  wire logic [11:0]            positionInteg,
    input  wire logic [11:0]            velocityInteg,
    input  wire logic                   resolverValid,
    input  wire logic                   sampleStrobe,
    input  wire logic                   selectN,
    input  wire logic                   readFrameN,
    input  wire logic                   velocitySelect,
    input  wire logic                   serialPortSelect,
    input  wire logic                   data10In,
    output logic [11:0]                 dataOut,
    output logic [11:0]                 dataOeN,
    output logic                        pumpSquareOut,
    output logic                        encoderA,
    output logic                        encoderB,
    output logic                        indexMarker,
    output logic                        rotationDir
);
    // Input history for edge detection; inputs are synchronous already
    logic                       sample_q;
    logic                       frameN_q;
    logic                       shiftClk_q;
    logic [11:0]                posReg_q;
    logic [11:0]                velReg_q;
    logic [1:0]                 ctrl_q;
    rdc_pkg::rdc_ser_state_t    serState_q;
    logic [11:0]                shift_q;
    logic [11:0]                dataOut_q;
    logic [11:0]                dataOeN_q;
    logic [5:0]                 pumpCnt_q;
    logic                       pump_q;
    logic [11:0]                prevPos_q;
    logic                       encA_q;
    logic                       encB_q;
    logic                       index_q;
    logic                       dir_q;
    // AXI state
    logic                       awHeld_q;
    logic                       wHeld_q;
    logic [7:0]                 awAddr_q;
    logic [31:0]                wData_q;
    logic                       wStrb0_q;
    logic                       awready_q;
    logic                       wready_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       arready_q;
    logic                       rvalid_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 rresp_q;

    // Address decode, shared by the write and read paths
    function automatic logic rdc_mapped(input logic [7:0] a);
        rdc_mapped = (a == rdc_pkg::ADDR_CTRL) || (a == rdc_pkg::ADDR_POS) ||
                     (a == rdc_pkg::ADDR_VEL) || (a == rdc_pkg::ADDR_STATUS);
    endfunction : rdc_mapped

    // Port events
    wire        sampleFall  = sample_q & ~sampleStrobe;
    wire        portActive  = ~selectN & ~readFrameN;
    wire        frameStart  = ~selectN & frameN_q & ~readFrameN;
    wire        shiftRise   = ~shiftClk_q & data10In;
    wire [11:0] selResult   = velocitySelect ? posReg_q : velReg_q;
    wire        serialMode  = serialPortSelect;

    // Strobe edge history; sample history resets low so a low strobe is no false fall
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sample_q   <= 1'b0;
            frameN_q   <= 1'b1;
            shiftClk_q <= 1'b0;
        end else begin
            sample_q   <= sampleStrobe;
            frameN_q   <= readFrameN;
            shiftClk_q <= data10In;
        end
    end

    // Result registers; the integrators keep running between samples
    always_ff @(posedge core_clk) begin
        if (reset) begin
            posReg_q <= 12'h000;
            velReg_q <= 12'h000;
        end else if (sampleFall) begin
            posReg_q <= positionInteg;
            velReg_q <= velocityInteg;
        end
    end

    // Serial engine: load on frame start, shift on each clock rise in frame
    always_ff @(posedge core_clk) begin
        if (reset) begin
            serState_q <= rdc_pkg::RDC_SER_IDLE;
            shift_q    <= 12'h000;
        end else begin
            case (serState_q)
                rdc_pkg::RDC_SER_IDLE: begin
                    if (frameStart && serialMode) begin
                        serState_q <= rdc_pkg::RDC_SER_SHIFT;
                        shift_q    <= selResult;
                    end
                end
                rdc_pkg::RDC_SER_SHIFT: begin
                    if (!portActive || !serialMode) begin
                        serState_q <= rdc_pkg::RDC_SER_IDLE;
                    end else if (shiftRise) begin
                        shift_q    <= {shift_q[10:0], 1'b0};
                    end
                end
                default: serState_q <= rdc_pkg::RDC_SER_IDLE;
            endcase
        end
    end

    // Pin drive; shift clock pin never driven in serial mode
    wire        serLoad     = frameStart & serialMode;
    wire        serBit      = serLoad ? selResult[11] : shift_q[11];
    wire [11:0] parOeN      = portActive ? 12'h000 : 12'hfff;
    wire [11:0] serOeN      = {~portActive, 11'h7ff};
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dataOut_q <= 12'h000;
            dataOeN_q <= 12'hfff;
        end else if (serialMode) begin
            dataOut_q <= {serBit, 11'h000};
            dataOeN_q <= serOeN;
        end else begin
            dataOut_q <= selResult;
            dataOeN_q <= parOeN;
        end
    end

    // Pump divider; the ratio is rounded down, so the rate sits just above the target
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pumpCnt_q <= 6'h00;
            pump_q    <= 1'b0;
        end else if (pumpCnt_q == rdc_pkg::PUMP_LAST) begin
            pumpCnt_q <= 6'h00;
            pump_q    <= ~pump_q & ctrl_q[rdc_pkg::CTRL_PUMP];
        end else begin
            pumpCnt_q <= pumpCnt_q + 6'h01;
        end
    end

    // Encoder emulation from the live angle; frozen while inputs are bad
    wire [11:0] posDelta = positionInteg - prevPos_q;
    wire        encRun   = resolverValid & ctrl_q[rdc_pkg::CTRL_ENC];
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prevPos_q <= 12'h000;
            encA_q    <= 1'b0;
            encB_q    <= 1'b0;
            index_q   <= 1'b0;
            dir_q     <= 1'b0;
        end else if (encRun) begin
            prevPos_q <= positionInteg;
            encA_q    <= positionInteg[1];
            encB_q    <= positionInteg[1] ^ positionInteg[0];
            index_q   <= (positionInteg == 12'h000);
            if (posDelta != 12'h000) begin
                dir_q <= ~posDelta[11];
            end
        end
    end

    // AXI write path: address and data taken in either order
    wire takeAw  = axiReq.awvalid & awready_q;
    wire takeW   = axiReq.wvalid & wready_q;
    wire doWrite = awHeld_q & wHeld_q & ~bvalid_q;
    wire awHeldD = (awHeld_q | takeAw) & ~doWrite;
    wire wHeldD  = (wHeld_q | takeW) & ~doWrite;
    wire bvalidD = doWrite | (bvalid_q & ~axiReq.bready);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awAddr_q  <= 8'h00;
            wData_q   <= 32'h0000_0000;
            wStrb0_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= rdc_pkg::RESP_OKAY;
            ctrl_q    <= rdc_pkg::CTRL_RESET;
        end else begin
            awHeld_q  <= awHeldD;
            wHeld_q   <= wHeldD;
            awready_q <= ~awHeldD & ~bvalidD;
            wready_q  <= ~wHeldD & ~bvalidD;
            bvalid_q  <= bvalidD;
            if (takeAw) begin
                awAddr_q <= axiReq.awaddr;
            end
            if (takeW) begin
                wData_q  <= axiReq.wdata;
                wStrb0_q <= axiReq.wstrb[0];
            end
            if (doWrite) begin
                bresp_q <= rdc_mapped(awAddr_q) ? rdc_pkg::RESP_OKAY : rdc_pkg::RESP_DECERR;
                if (awAddr_q == rdc_pkg::ADDR_CTRL && wStrb0_q) begin
                    ctrl_q <= wData_q[1:0];
                end
            end
        end
    end

    // AXI read path, one beat in flight
    wire        takeAr  = axiReq.arvalid & arready_q;
    wire        rvalidD = takeAr | (rvalid_q & ~axiReq.rready);
    wire [31:0] status  = {29'h0000_0000, serState_q, serialMode, dir_q};
    wire [31:0] rdWord  = (axiReq.araddr == rdc_pkg::ADDR_CTRL)   ? {30'h0000_0000, ctrl_q} :
                          (axiReq.araddr == rdc_pkg::ADDR_POS)    ? {20'h00000, posReg_q} :
                          (axiReq.araddr == rdc_pkg::ADDR_VEL)    ? {20'h00000, velReg_q} :
                          (axiReq.araddr == rdc_pkg::ADDR_STATUS) ? status : 32'h0000_0000;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= rdc_pkg::RESP_OKAY;
        end else begin
            arready_q <= ~rvalidD;
            rvalid_q  <= rvalidD;
            if (takeAr) begin
                rdata_q <= rdWord;
                rresp_q <= rdc_mapped(axiReq.araddr) ? rdc_pkg::RESP_OKAY : rdc_pkg::RESP_DECERR;
            end
        end
    end

    // Outputs straight from flops
    assign axiRsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                      arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};
    assign dataOut       = dataOut_q;
    assign dataOeN       = dataOeN_q;
    assign pumpSquareOut = pump_q;
    assign encoderA      = encA_q;
    assign encoderB      = encB_q;
    assign indexMarker   = index_q;
    assign rotationDir   = dir_q;

    // Checks next to the logic they guard
    a_sample_latch: assert property (@(posedge core_clk) disable iff (reset)
        sampleFall |=> posReg_q == $past(positionInteg) && velReg_q == $past(velocityInteg))
        else $error("Sample fall did not latch integrators");
    a_idle_release: assert property (@(posedge core_clk) disable iff (reset)
        (selectN || readFrameN) |=> dataOeN_q == 12'hfff)
        else $error("Data pins driven while port inactive");
    a_par_select: assert property (@(posedge core_clk) disable iff (reset)
        (portActive && !serialMode) |=> dataOeN_q == 12'h000 &&
            dataOut_q == (($past(velocitySelect)) ? $past(posReg_q) : $past(velReg_q)))
        else $error("Parallel read shows wrong register");
    a_sclk_undriven: assert property (@(posedge core_clk) disable iff (reset)
        serialMode |=> dataOeN_q[10:0] == 11'h7ff)
        else $error("Shift clock pin driven in serial mode");
    a_frame_load: assert property (@(posedge core_clk) disable iff (reset)
        (frameStart && serialMode) |=> serState_q == rdc_pkg::RDC_SER_SHIFT &&
            dataOut_q[11] == $past(selResult[11]) && !dataOeN_q[11])
        else $error("Frame start did not present MSB");
    a_shift_step: assert property (@(posedge core_clk) disable iff (reset)
        (serState_q == rdc_pkg::RDC_SER_SHIFT && portActive && serialMode && shiftRise)
            |=> shift_q == {$past(shift_q[10:0]), 1'b0})
        else $error("Serial shift did not advance on clock rise");
    a_pump_toggle: assert property (@(posedge core_clk) disable iff (reset)
        (pumpCnt_q != rdc_pkg::PUMP_LAST) |=> $stable(pump_q))
        else $error("Pump output changed mid half period");
    a_enc_hold: assert property (@(posedge core_clk) disable iff (reset)
        !resolverValid |=> $stable(encA_q) && $stable(encB_q) && $stable(dir_q))
        else $error("Encoder outputs moved with invalid inputs");
    a_index_mark: assert property (@(posedge core_clk) disable iff (reset)
        (encRun && positionInteg == 12'h000) |=> index_q)
        else $error("Index marker missed zero angle");
    a_dir_up: assert property (@(posedge core_clk) disable iff (reset)
        (encRun && posDelta != 12'h000 && !posDelta[11]) |=> dir_q)
        else $error("Direction not high for rising angle");
endmodule : rdc_readout_port
`default_nettype wire

// *** verification/rdc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdc_host_model (
    input  wire logic        core_clk,
    input  wire logic [11:0] dataOut,
    input  wire logic [11:0] dataOeN,
    output logic             selectN,
    output logic             readFrameN,
    output logic             velocitySelect,
    output logic             serialPortSelect,
    output logic             data10In
);
    // Pins as the host sees them; a released pin reads back inverted, never stale
    wire logic [11:0] pinSeen = dataOut ^ dataOeN;

    // Idle host: deselected, shift clock parked low between frames
    initial begin
        selectN = 1'h1;
        readFrameN = 1'h1;
        velocitySelect = 1'h1;
        serialPortSelect = 1'h0;
        data10In = 1'h0;
    end

    // Parallel read; posSel high picks the position register
    task readParallel(input logic posSel, output logic [11:0] word, output logic [11:0] oe);
        @(posedge core_clk);
        serialPortSelect <= 1'h0;
        velocitySelect <= posSel;
        selectN <= 1'h0;
        readFrameN <= 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        word = pinSeen;
        oe = dataOeN;
        @(posedge core_clk);
        selectN <= 1'h1;
        readFrameN <= 1'h1;
    endtask : readParallel

    // Frame strobe low with the port deselected; nothing may be driven
    task readDeselected(output logic [11:0] oe);
        @(posedge core_clk);
        readFrameN <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        oe = dataOeN;
        @(posedge core_clk);
        readFrameN <= 1'h1;
    endtask : readDeselected

    // Serial frame: mode and selector settle before the frame edge
    task readSerial(input logic posSel, output logic [11:0] word, output logic [11:0] oe);
        @(posedge core_clk);
        serialPortSelect <= 1'h1;
        velocitySelect <= posSel;
        selectN <= 1'h0;
        repeat (2) @(posedge core_clk);
        readFrameN <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1;
        oe = dataOeN;
        for (int i = 0; i < 12; i++) begin
            word = {word[10:0], pinSeen[11]};
            oe = oe & dataOeN;
            @(posedge core_clk);
            data10In <= 1'h1;
            @(posedge core_clk);
            data10In <= 1'h0;
            repeat (3) @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        selectN <= 1'h1;
        readFrameN <= 1'h1;
        serialPortSelect <= 1'h0;
    endtask : readSerial
endmodule : rdc_host_model
`default_nettype wire

// *** verification/rdc_readout_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rdc_readout_port_tb;
    logic                   core_clk;
    logic                   reset;
    rdc_pkg::rdc_axil_req_t axiReq;
    rdc_pkg::rdc_axil_rsp_t axiRsp;
    logic [11:0]            positionInteg, velocityInteg, dataOut, dataOeN, w, oe;
    logic                   resolverValid, sampleStrobe, selectN, readFrameN;
    logic                   velocitySelect, serialPortSelect, data10In, pumpSquareOut;
    logic                   encoderA, encoderB, indexMarker, rotationDir;
    logic [31:0]            rd;
    logic [1:0]             rs;
    int                     nMismatch, testsRun, cycles;

    rdc_readout_port DUT (.core_clk, .reset, .axiReq, .axiRsp, .positionInteg, .velocityInteg,
        .resolverValid, .sampleStrobe, .selectN, .readFrameN, .velocitySelect,
        .serialPortSelect, .data10In, .dataOut, .dataOeN, .pumpSquareOut, .encoderA,
        .encoderB, .indexMarker, .rotationDir);

    rdc_host_model HOST (.core_clk, .dataOut, .dataOeN, .selectN, .readFrameN,
        .velocitySelect, .serialPortSelect, .data10In);

    // Clock at 20 MHz
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            reportAndStop();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task reportAndStop();
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : reportAndStop

    // Write with address and data offered together, each dropped when taken
    task axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge core_clk);
        axiReq.awvalid <= 1'h1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'h1;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'h0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'h0;
            if (axiRsp.bvalid) begin
                resp = axiRsp.bresp;
                axiReq.bready <= 1'h0;
                break;
            end
        end
    endtask : axiWrite

    task axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge core_clk);
        axiReq.arvalid <= 1'h1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'h0;
            if (axiRsp.rvalid) begin
                d = axiRsp.rdata;
                resp = axiRsp.rresp;
                axiReq.rready <= 1'h0;
                break;
            end
        end
    endtask : axiRead

    // Load the integrators, then a one-cycle high pulse gives the falling edge
    task setSample(input logic [11:0] p, input logic [11:0] v);
        @(posedge core_clk);
        positionInteg <= p;
        velocityInteg <= v;
        sampleStrobe <= 1'h1;
        @(posedge core_clk);
        sampleStrobe <= 1'h0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : setSample

    task testRegs();
        axiRead(rdc_pkg::ADDR_CTRL, rd, rs);
        chk("ctrl reset", 32'h3, rd);
        chk("oe idle", 32'hfff, 32'(dataOeN));
        axiRead(8'h40, rd, rs);
        chk("unmapped read", 32'(rdc_pkg::RESP_DECERR), 32'(rs));
        axiWrite(8'h44, 32'h1, rs);
        chk("unmapped write", 32'(rdc_pkg::RESP_DECERR), 32'(rs));
        $display("test registers done");
    endtask : testRegs

    // Integrators move after the strobe; the registers must keep the sample
    task testSample();
        setSample(12'h5a3, 12'h0c7);
        positionInteg <= 12'h111;
        velocityInteg <= 12'h222;
        axiRead(rdc_pkg::ADDR_POS, rd, rs);
        chk("pos reg", 32'h5a3, rd);
        axiRead(rdc_pkg::ADDR_VEL, rd, rs);
        chk("vel reg", 32'h0c7, rd);
        $display("test sample done");
    endtask : testSample

    task testParallel();
        HOST.readParallel(1'h1, w, oe);
        chk("par pos", 32'h5a3, 32'(w));
        chk("par oe", 32'h0, 32'(oe));
        HOST.readParallel(1'h0, w, oe);
        chk("par vel", 32'h0c7, 32'(w));
        HOST.readDeselected(oe);
        chk("desel oe", 32'hfff, 32'(oe));
        $display("test parallel done");
    endtask : testParallel

    task testSerial();
        HOST.readSerial(1'h1, w, oe);
        chk("ser pos", 32'h5a3, 32'(w));
        chk("ser oe", 32'h7ff, 32'(oe));
        HOST.readSerial(1'h0, w, oe);
        chk("ser vel", 32'h0c7, 32'(w));
        // Release is seen and registered at the first edge; the second edge is slack
        repeat (2) @(posedge core_clk);
        #1;
        chk("oe after", 32'hfff, 32'(dataOeN));
        $display("test serial done");
    endtask : testSerial

    // Quadrature, index and direction follow the live angle
    task testEncoder();
        setSample(12'h000, 12'h0);
        chk("enc zero", 32'h1, 32'({encoderA, encoderB, indexMarker}));
        setSample(12'h003, 12'h0);
        chk("enc up", 32'h9, 32'({encoderA, encoderB, indexMarker, rotationDir}));
        setSample(12'h002, 12'h0);
        chk("enc down", 32'hc, 32'({encoderA, encoderB, indexMarker, rotationDir}));
        // Invalid resolver inputs freeze the outputs, so angle zero must not show
        @(posedge core_clk);
        resolverValid <= 1'h0;
        setSample(12'h000, 12'h0);
        chk("enc frozen", 32'hc, 32'({encoderA, encoderB, indexMarker, rotationDir}));
        @(posedge core_clk);
        resolverValid <= 1'h1;
        $display("test encoder done");
    endtask : testEncoder

    // Half periods measured in cycles, then the pump output is switched off
    task testPump();
        int n;
        // The output is read 1 ns after each edge, once it has settled
        while (pumpSquareOut !== 1'h0) begin
            @(posedge core_clk);
            #1;
        end
        while (pumpSquareOut !== 1'h1) begin
            @(posedge core_clk);
            #1;
        end
        n = 0;
        while (pumpSquareOut === 1'h1) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk("pump high", 32'(rdc_pkg::PUMP_HALF), 32'(n));
        n = 0;
        while (pumpSquareOut === 1'h0) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk("pump low", 32'(rdc_pkg::PUMP_HALF), 32'(n));
        axiWrite(rdc_pkg::ADDR_CTRL, 32'h2, rs);
        repeat (100) @(posedge core_clk);
        #1;
        chk("pump off", 32'h0, 32'(pumpSquareOut));
        $display("test pump done");
    endtask : testPump

    // Main sequence
    initial begin
        axiReq = '0;
        reset = 1'h1;
        positionInteg = 12'h0;
        velocityInteg = 12'h0;
        resolverValid = 1'h1;
        sampleStrobe = 1'h0;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        testRegs();
        testSample();
        testParallel();
        testSerial();
        testEncoder();
        testPump();
        reportAndStop();
    end
endmodule : rdc_readout_port_tb
`default_nettype wire
